//--- pkg/acd_cfg.svh
`ifndef ACD_CFG_SVH
`define ACD_CFG_SVH

// clock rate and timing figures
`define ACD_CLK_HZ        50000000
`define ACD_PERIOD_MS     60
`define ACD_STEP_US       100

// bus address: six fixed bits, then the address-select pin, then write bit
`define ACD_DEV_ADDR_HI   6'h3E
`define ACD_RW_WRITE      1'b0

// register select codes in the top three bits of a data byte
`define ACD_SEL_MODE      3'h0
`define ACD_SEL_DIAG      3'h1
`define ACD_SEL_MASK      3'h2
`define ACD_SEL_GAIN_A    3'h3
`define ACD_SEL_GAIN_B    3'h4

// mode_select fields
`define ACD_MODE_IN_A     2
`define ACD_MODE_IN_B     3
`define ACD_MODE_POWER    4
`define ACD_MODE_USED     5'h1C

// diag_ctrl fields
`define ACD_DIAG_ILIM     1
`define ACD_DIAG_CLR      2
`define ACD_DIAG_REPEAT   3
`define ACD_DIAG_ARM      4
`define ACD_DIAG_USED     5'h1E

// fault_mask fields, also the bit order of the fault vectors
`define ACD_FLT_BRIDGE    0
`define ACD_FLT_OPEN      1
`define ACD_FLT_SUPPLY    2
`define ACD_FLT_OVERCUR   3
`define ACD_FLT_THERMAL   4

// reset value of every payload
`define ACD_RST_PAYLOAD   5'h00

`endif

//--- pkg/acd_pkg.sv
package acd_pkg;

  // serial receiver states, gray along idle -> address -> data
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_ADDR = 2'h1,
    RX_DATA = 2'h3
  } acd_rx_state_t;

  // diagnostic sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    DG_IDLE   = 3'h0,
    DG_SUPPLY = 3'h1,
    DG_BRIDGE = 3'h3,
    DG_OPEN   = 3'h2,
    DG_WAIT   = 3'h6
  } acd_diag_state_t;

endpackage

//--- pkg/acd_wr_if.sv
interface acd_wr_if;
  logic       valid;   // one-cycle pulse per received data byte
  logic [7:0] data;    // select in [7:5], payload in [4:0]

  modport src (output valid, output data);
  modport snk (input valid, input data);
endinterface

//--- rtl/acd_ctrl_top.sv
// Overview of operation
// RULE1: answer bus address 111110 plus address-select pin, write direction only.
// RULE2: data byte top three bits pick register 0-4, low five bits payload.
// RULE3: mode bits: B2 input one, B3 input two, B4 power on; B0-B1 reserved.
// RULE4: no input mutes, one input passes alone, both inputs are summed.
// RULE5: power-up runs full diagnostic in shutdown, regardless of arm bit.
// RULE6: writes arriving during power-up diagnostic are held, applied afterwards.
// RULE7: writing fault-clear as 1 aborts the power-up diagnostic early.
// RULE8: arm bit rising from 0 to 1 launches one diagnostic sequence.
// RULE9: one-shot mode ignores arm until master writes it 0 then 1.
// RULE10: continuous mode repeats every 60ms; stops on fault, clear cycle, mode off.
// RULE11: master sets repeat bit before arm for continuous; repeat 0 is one-shot.
// RULE12: arm at 0 skips short/open tests; thermal and over-current still protect.
// RULE13: fault-clear at 0 keeps faults latched; toggling re-enables outputs, releases line.
// RULE14: diag bit B1 picks fixed (0) or supply-dependent (1) current limit.
// RULE15: a mask bit set hides its test from the fault line, protection stays.
// RULE16: mask bits: B0 bridge short, B1 open, B2 supply short, B3 overcurrent, B4 thermal.
// RULE17: a launched sequence runs every test whatever the mask bits hold.
// RULE18: fault line stays low after the condition goes, until clear toggles.
// RULE19: registers 3 and 4 hold 5-bit gain codes, 00000 lowest, 11111 highest.
// RULE20: registers are write-only and reserved payload bits are dropped.
`include "acd_cfg.svh"
module acd_ctrl_top
  import acd_pkg::*;
#(
  parameter int STEP_CYC   = `ACD_STEP_US * (`ACD_CLK_HZ / 1000000),
  parameter int PERIOD_CYC = `ACD_PERIOD_MS * (`ACD_CLK_HZ / 1000)
)
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  input  wire logic       adr_sel_in,
  input  wire logic [4:0] fault_cond_in,
  output logic            fault_out,
  output logic            fault_oe_n_out,
  output logic            amp_enable_out,
  output logic            in_a_sel_out,
  output logic            in_b_sel_out,
  output logic            mute_out,
  output logic [4:0]      gain_a_code_out,
  output logic [4:0]      gain_b_code_out,
  output logic            current_limit_sel_out,
  output logic            test_supply_out,
  output logic            test_bridge_out,
  output logic            test_open_out,
  output logic            diag_busy_out
);

  acd_wr_if wr_bus ();

  acd_diag_state_t state_reg;
  logic            pwrup_reg;
  logic [31:0]     step_cnt_reg;
  logic [31:0]     period_cnt_reg;
  logic [4:0]      mode_shadow_reg;
  logic [4:0]      diag_shadow_reg;
  logic [4:0]      mask_shadow_reg;
  logic [4:0]      gain_a_shadow_reg;
  logic [4:0]      gain_b_shadow_reg;
  logic [4:0]      mode_reg;
  logic [4:0]      diag_reg;
  logic [4:0]      mask_reg;
  logic [4:0]      gain_a_reg;
  logic [4:0]      gain_b_reg;
  logic            arm_prev_reg;
  logic            clr_prev_reg;
  logic [4:0]      cond_s1_reg;
  logic [4:0]      cond_s2_reg;
  logic            protect_reg;
  logic [4:0]      flag_reg;
  logic [4:0]      detect;
  logic            arm_rise;
  logic            clr_toggle;
  logic            abort_pwrup;
  logic            step_done;
  logic            any_detect;
  logic [2:0]      wr_sel;
  logic [4:0]      wr_payload;

  // serial byte receiver
  acd_i2c_rx u_rx (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .adr_sel_in   (adr_sel_in),
    .sda_oe_n_out (sda_oe_n_out),
    .wr           (wr_bus.src)
  );

  // open-drain data pin only ever pulls low
  assign sda_out = 1'b0;

  // split each received byte into select and payload
  assign wr_sel     = wr_bus.data[7:5];   // see RULE2
  assign wr_payload = wr_bus.data[4:0];

  // shadow copies take every write to selects 0-4, reserved bits dropped
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      mode_shadow_reg   <= `ACD_RST_PAYLOAD;
      diag_shadow_reg   <= `ACD_RST_PAYLOAD;
      mask_shadow_reg   <= `ACD_RST_PAYLOAD;
      gain_a_shadow_reg <= `ACD_RST_PAYLOAD;
      gain_b_shadow_reg <= `ACD_RST_PAYLOAD;
    end
    else if (wr_bus.valid)
    begin
      case (wr_sel)                                             // see RULE2
        `ACD_SEL_MODE:   mode_shadow_reg   <= wr_payload & `ACD_MODE_USED;  // see RULE20
        `ACD_SEL_DIAG:   diag_shadow_reg   <= wr_payload & `ACD_DIAG_USED;  // see RULE20
        `ACD_SEL_MASK:   mask_shadow_reg   <= wr_payload;
        `ACD_SEL_GAIN_A: gain_a_shadow_reg <= wr_payload;                   // see RULE19
        `ACD_SEL_GAIN_B: gain_b_shadow_reg <= wr_payload;                   // see RULE19
        default:         mode_shadow_reg   <= mode_shadow_reg;  // selects 5-7 ignored
      endcase
    end

  // working registers follow the shadows once power-up checking is over
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      mode_reg   <= `ACD_RST_PAYLOAD;
      diag_reg   <= `ACD_RST_PAYLOAD;
      mask_reg   <= `ACD_RST_PAYLOAD;
      gain_a_reg <= `ACD_RST_PAYLOAD;
      gain_b_reg <= `ACD_RST_PAYLOAD;
    end
    else if (!pwrup_reg)                                        // see RULE6
    begin
      mode_reg   <= mode_shadow_reg;
      diag_reg   <= diag_shadow_reg;
      mask_reg   <= mask_shadow_reg;
      gain_a_reg <= gain_a_shadow_reg;
      gain_b_reg <= gain_b_shadow_reg;
    end

  // last applied arm and clear levels, for edge and toggle finding
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      arm_prev_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
    end
    else
    begin
      arm_prev_reg <= diag_reg[`ACD_DIAG_ARM];
      clr_prev_reg <= diag_reg[`ACD_DIAG_CLR];
    end

  assign arm_rise   = diag_reg[`ACD_DIAG_ARM] & ~arm_prev_reg;   // see RULE8
  assign clr_toggle = diag_reg[`ACD_DIAG_CLR] ^ clr_prev_reg;    // see RULE13

  // a clear written as 1 stops the power-up run at once
  assign abort_pwrup = pwrup_reg & wr_bus.valid & (wr_sel == `ACD_SEL_DIAG)
                     & wr_payload[`ACD_DIAG_CLR];                // see RULE7

  // fault conditions from the analog side pass two flip-flops
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      cond_s1_reg <= 5'h00;
      cond_s2_reg <= 5'h00;
    end
    else
    begin
      cond_s1_reg <= fault_cond_in;
      cond_s2_reg <= cond_s1_reg;
    end

  // load tests count only in their own step; thermal and current always
  always_comb
  begin
    detect                   = 5'h00;
    detect[`ACD_FLT_SUPPLY]  = cond_s2_reg[`ACD_FLT_SUPPLY] & (state_reg == DG_SUPPLY);
    detect[`ACD_FLT_BRIDGE]  = cond_s2_reg[`ACD_FLT_BRIDGE] & (state_reg == DG_BRIDGE);
    detect[`ACD_FLT_OPEN]    = cond_s2_reg[`ACD_FLT_OPEN] & (state_reg == DG_OPEN);
    detect[`ACD_FLT_OVERCUR] = cond_s2_reg[`ACD_FLT_OVERCUR];   // see RULE12
    detect[`ACD_FLT_THERMAL] = cond_s2_reg[`ACD_FLT_THERMAL];   // see RULE12
  end

  assign any_detect = |detect;
  assign step_done  = step_cnt_reg == 32'(STEP_CYC - 1);

  // diagnostic sequencer: supply short, bridge short, open load, then wait if repeat is set, else idle
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      state_reg <= DG_SUPPLY;                                   // see RULE5
      pwrup_reg <= 1'b1;                                        // see RULE5
    end
    else if (abort_pwrup)
    begin
      state_reg <= DG_IDLE;                                     // see RULE7
      pwrup_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        DG_IDLE:
          if (arm_rise)                                         // see RULE8
            state_reg <= DG_SUPPLY;                             // see RULE9
        DG_SUPPLY:
          if (any_detect)
          begin
            state_reg <= DG_IDLE;                               // see RULE10
            pwrup_reg <= 1'b0;
          end
          else if (step_done)
            state_reg <= DG_BRIDGE;                             // see RULE17
        DG_BRIDGE:
          if (any_detect)
          begin
            state_reg <= DG_IDLE;                               // see RULE10
            pwrup_reg <= 1'b0;
          end
          else if (step_done)
            state_reg <= DG_OPEN;                               // see RULE17
        DG_OPEN:
          if (any_detect || (step_done && pwrup_reg))
          begin
            state_reg <= DG_IDLE;
            pwrup_reg <= 1'b0;
          end
          else if (step_done)
            state_reg <= diag_reg[`ACD_DIAG_REPEAT] ? DG_WAIT : DG_IDLE;  // see RULE10
        DG_WAIT:
          if (any_detect || clr_toggle || !diag_reg[`ACD_DIAG_REPEAT])
            state_reg <= DG_IDLE;                               // see RULE10
          else if (period_cnt_reg >= 32'(PERIOD_CYC - 1))
            state_reg <= DG_SUPPLY;                             // see RULE10
        default:
        begin
          state_reg <= DG_IDLE;
          pwrup_reg <= 1'b0;
        end
      endcase
    end

  // step timer restarts on every state change
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      step_cnt_reg <= 32'h0000_0000;
    else if (state_reg == DG_IDLE || state_reg == DG_WAIT || step_done || abort_pwrup)
      step_cnt_reg <= 32'h0000_0000;
    else
      step_cnt_reg <= step_cnt_reg + 32'h0000_0001;

  // repeat timer measures launch to launch
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      period_cnt_reg <= 32'h0000_0000;
    else if (state_reg == DG_IDLE
             || (state_reg == DG_WAIT && period_cnt_reg >= 32'(PERIOD_CYC - 1)))
      period_cnt_reg <= 32'h0000_0000;
    else
      period_cnt_reg <= period_cnt_reg + 32'h0000_0001;

  // protective shutdown latch ignores masks; a fresh fault beats the clear
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      protect_reg <= 1'b0;
    else
      protect_reg <= (protect_reg & ~clr_toggle) | any_detect;  // see RULE13 RULE15

  // fault line flags, unmasked tests only, held until clear toggles
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      flag_reg <= 5'h00;
    else
      flag_reg <= (flag_reg & ~{5{clr_toggle}})                 // see RULE18
                | (detect & ~mask_reg);                         // see RULE15 RULE16

  // open-drain fault pin pulled low while any flag stands
  assign fault_out      = 1'b0;
  assign fault_oe_n_out = ~|flag_reg;                           // see RULE13

  // amplifier enable: powered, past power-up, no protective shutdown
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      amp_enable_out <= 1'b0;
    else
      amp_enable_out <= mode_reg[`ACD_MODE_POWER] & ~pwrup_reg  // see RULE3 RULE5
                      & ~protect_reg & ~any_detect;             // see RULE12

  // source selection: mute, one input, or the mix of both
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      in_a_sel_out <= 1'b0;
      in_b_sel_out <= 1'b0;
      mute_out     <= 1'b1;
    end
    else
    begin
      in_a_sel_out <= mode_reg[`ACD_MODE_IN_A];                 // see RULE3 RULE4
      in_b_sel_out <= mode_reg[`ACD_MODE_IN_B];                 // see RULE3 RULE4
      mute_out     <= ~mode_reg[`ACD_MODE_IN_A] & ~mode_reg[`ACD_MODE_IN_B];  // see RULE4
    end

  // gain codes and current limit selection
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      gain_a_code_out       <= `ACD_RST_PAYLOAD;
      gain_b_code_out       <= `ACD_RST_PAYLOAD;
      current_limit_sel_out <= 1'b0;
    end
    else
    begin
      gain_a_code_out       <= gain_a_reg;                      // see RULE19
      gain_b_code_out       <= gain_b_reg;                      // see RULE19
      current_limit_sel_out <= diag_reg[`ACD_DIAG_ILIM];        // see RULE14
    end

  // test strobes to the analog measurement, one per step
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      test_supply_out <= 1'b0;
      test_bridge_out <= 1'b0;
      test_open_out   <= 1'b0;
      diag_busy_out   <= 1'b0;
    end
    else
    begin
      test_supply_out <= state_reg == DG_SUPPLY;
      test_bridge_out <= state_reg == DG_BRIDGE;
      test_open_out   <= state_reg == DG_OPEN;
      diag_busy_out   <= state_reg != DG_IDLE;
    end

endmodule

//--- rtl/acd_i2c_rx.sv
module acd_i2c_rx
  import acd_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic adr_sel_in,
  output logic      sda_oe_n_out,
  acd_wr_if.src     wr
);
`include "acd_cfg.svh"

  logic [2:0]    sync1_reg;
  logic [2:0]    sync2_reg;
  logic [1:0]    prev_reg;
  acd_rx_state_t state_reg;
  logic [7:0]    shift_reg;
  logic [3:0]    cnt_reg;
  logic          ack_reg;
  logic          drv_reg;
  logic          valid_reg;
  logic [7:0]    data_reg;
  logic          scl_s;
  logic          sda_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;
  logic          addr_hit;

  // two flip-flops on each pin: scl, sda, address select
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end
    else
    begin
      sync1_reg <= {adr_sel_in, sda_in, scl_in};
      sync2_reg <= sync1_reg;
    end

  // previous synchronised levels for edge finding
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      prev_reg <= 2'h3;
    else
      prev_reg <= sync2_reg[1:0];

  // bus events seen on the synchronised lines
  assign scl_s     = sync2_reg[0];
  assign sda_s     = sync2_reg[1];
  assign scl_rise  = scl_s & ~prev_reg[0];
  assign scl_fall  = ~scl_s & prev_reg[0];
  assign start_det = scl_s & prev_reg[0] & ~sda_s & prev_reg[1];
  assign stop_det  = scl_s & prev_reg[0] & sda_s & ~prev_reg[1];
  // see RULE1
  assign addr_hit  = shift_reg == {`ACD_DEV_ADDR_HI, sync2_reg[2], `ACD_RW_WRITE};

  // frame state, bit shifting and acknowledge drive
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      state_reg <= RX_IDLE;
      shift_reg <= 8'h00;
      cnt_reg   <= 4'h0;
      ack_reg   <= 1'b0;
      drv_reg   <= 1'b0;
      valid_reg <= 1'b0;
      data_reg  <= 8'h00;
    end
    else
    begin
      valid_reg <= 1'b0;
      if (start_det)
      begin
        state_reg <= RX_ADDR;
        cnt_reg   <= 4'h0;
        ack_reg   <= 1'b0;
        drv_reg   <= 1'b0;
      end
      else if (stop_det)
      begin
        state_reg <= RX_IDLE;
        ack_reg   <= 1'b0;
        drv_reg   <= 1'b0;
      end
      else if (scl_rise && state_reg != RX_IDLE && !ack_reg && cnt_reg != 4'h8)
      begin
        shift_reg <= {shift_reg[6:0], sda_s};
        cnt_reg   <= cnt_reg + 4'h1;
      end
      else if (scl_fall && ack_reg)
      begin
        ack_reg <= 1'b0;
        drv_reg <= 1'b0;
        cnt_reg <= 4'h0;
      end
      else if (scl_fall && cnt_reg == 4'h8)
      begin
        case (state_reg)
          RX_ADDR:
            if (addr_hit)            // reads and other addresses get no ack
            begin
              state_reg <= RX_DATA;
              ack_reg   <= 1'b1;
              drv_reg   <= 1'b1;
            end
            else
              state_reg <= RX_IDLE;
          RX_DATA:
          begin
            ack_reg   <= 1'b1;
            drv_reg   <= 1'b1;
            valid_reg <= 1'b1;
            data_reg  <= shift_reg;
          end
          default:
            state_reg <= RX_IDLE;
        endcase
      end
    end

  assign sda_oe_n_out = ~drv_reg;
  assign wr.valid     = valid_reg;
  assign wr.data      = data_reg;

endmodule

//--- verification/acd_bus_master.sv
module acd_bus_master
(
  input  wire logic clk_in,
  input  wire logic sda_oe_n_in,
  output logic      scl_out,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idles released: clock stands high, data pulled up
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // a quarter of the 160 ns bus period, changes land on falling clock edges
  task automatic q();
    repeat (2) @(negedge clk_in);
  endtask

  // one bit; returns the open-drain wire level seen while the clock is high
  task automatic bit_io(input logic b, output logic s);
    sda_out = b;
    q();
    scl_out = 1'b1;
    q();
    s = sda_out & sda_oe_n_in;
    q();
    scl_out = 1'b0;
    q();
  endtask

  // eight bits msb first, then a released ninth bit for the acknowledge
  task automatic byte_io(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // start, address byte with direction bit, one data byte, stop
  task automatic write_reg(input logic [7:0] adr_byte, input logic [7:0] data,
                           output logic [1:0] acks);
    sda_out = 1'b0;
    q();
    scl_out = 1'b0;
    q();
    byte_io(adr_byte, acks[1]);
    byte_io(data, acks[0]);
    sda_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_out = 1'b1;
    q();
    q();
  endtask
endmodule

//--- verification/acd_ctrl_assertions.sv
module acd_ctrl_assertions
#(
  parameter int STEP_CYC   = 8,
  parameter int PERIOD_CYC = 64
)
(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       scl_in,
  input wire logic       sda_oe_n_out,
  input wire logic       fault_oe_n_out,
  input wire logic       amp_enable_out,
  input wire logic       in_a_sel_out,
  input wire logic       in_b_sel_out,
  input wire logic       mute_out,
  input wire logic [4:0] gain_a_code_out,
  input wire logic [4:0] gain_b_code_out,
  input wire logic       current_limit_sel_out,
  input wire logic       test_supply_out,
  input wire logic       test_bridge_out,
  input wire logic       test_open_out,
  input wire logic       diag_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] run_cnt_reg;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // counts unbroken cycles with some test strobe high
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      run_cnt_reg <= 32'h0;
    else
      run_cnt_reg <= (test_supply_out | test_bridge_out | test_open_out) ? run_cnt_reg + 1 : 32'h0;

  // bus clock idle high and sequencer idle for eight cycles
  sequence s_quiet;
    (scl_in && !diag_busy_out)[*8];
  endsequence

  mute_follows_a: assert property (mute_out == !(in_a_sel_out || in_b_sel_out))
    else $error("mute disagrees with input selects");
  fault_disables_a: assert property ($fell(fault_oe_n_out) |-> ##[0:3] !amp_enable_out)
    else $error("fault line low but outputs still on");
  bridge_after_a: assert property ($rose(test_bridge_out) |-> $past(test_supply_out))
    else $error("bridge test not preceded by supply test");
  open_after_a: assert property ($rose(test_open_out) |-> $past(test_bridge_out))
    else $error("open test not preceded by bridge test");
  one_step_a: assert property ($onehot0({test_supply_out, test_bridge_out, test_open_out}))
    else $error("two test strobes high at once");
  step_len_a: assert property (run_cnt_reg <= 3 * STEP_CYC)
    else $error("test sequence longer than three steps");
  pu_shut_a: assert property ($fell(rst_in) |-> ##1 (!amp_enable_out until !diag_busy_out))
    else $error("outputs enabled during power-up run");
  pu_bound_a: assert property ($fell(rst_in) |-> ##[1:1000] !diag_busy_out)
    else $error("power-up run does not end");
  fault_held_a: assert property (s_quiet ##0 !fault_oe_n_out |=> !fault_oe_n_out)
    else $error("fault line released without a clear write");
  cfg_steady_a: assert property (s_quiet |=> $stable({gain_a_code_out, gain_b_code_out,
      in_a_sel_out, in_b_sel_out, current_limit_sel_out}))
    else $error("settings changed with the bus idle");
  ack_len_a: assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out[*4] ##[1:20] sda_oe_n_out)
    else $error("acknowledge pulse of wrong length");
endmodule

bind acd_ctrl_top acd_ctrl_assertions #(.STEP_CYC(STEP_CYC), .PERIOD_CYC(PERIOD_CYC)) u_chk
(
  .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_oe_n_out(sda_oe_n_out),
  .fault_oe_n_out(fault_oe_n_out), .amp_enable_out(amp_enable_out),
  .in_a_sel_out(in_a_sel_out), .in_b_sel_out(in_b_sel_out), .mute_out(mute_out),
  .gain_a_code_out(gain_a_code_out), .gain_b_code_out(gain_b_code_out),
  .current_limit_sel_out(current_limit_sel_out), .test_supply_out(test_supply_out),
  .test_bridge_out(test_bridge_out), .test_open_out(test_open_out),
  .diag_busy_out(diag_busy_out)
);

//--- verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk_in;
  logic       rst_in;
  logic       scl;
  logic       sda_m;
  logic       adr_sel;
  logic       clr;
  logic [4:0] fault_cond;
  logic       sda_oe_n, fault_oe_n, amp_en, in_a, in_b, mute, ilim, t_sup, t_brg, t_open, busy;
  logic [4:0] gain_a, gain_b;
  int         miscompares = 0;
  int         check_count = 0;
  int         cycles = 0;

  acd_ctrl_top #(.STEP_CYC(100), .PERIOD_CYC(400)) DUT
  (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_m & sda_oe_n), .sda_out(),
    .sda_oe_n_out(sda_oe_n), .adr_sel_in(adr_sel), .fault_cond_in(fault_cond),
    .fault_out(), .fault_oe_n_out(fault_oe_n), .amp_enable_out(amp_en),
    .in_a_sel_out(in_a), .in_b_sel_out(in_b), .mute_out(mute), .gain_a_code_out(gain_a),
    .gain_b_code_out(gain_b), .current_limit_sel_out(ilim), .test_supply_out(t_sup),
    .test_bridge_out(t_brg), .test_open_out(t_open), .diag_busy_out(busy)
  );

  acd_bus_master bm (.clk_in(clk_in), .sda_oe_n_in(sda_oe_n), .scl_out(scl), .sda_out(sda_m));

  // 50 MHz system clock
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // cuts a hang short
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    chk(name, {4'h0, exp}, {4'h0, got});
  endtask

  // one acknowledged write to our own address
  task automatic wr(input logic [7:0] d);
    logic [1:0] acks;
    bm.write_reg(8'hFA, d, acks);
    chk("ack", 5'h03, {3'h0, acks});
  endtask

  // diag byte keeping the current fault-clear level
  function automatic logic [7:0] dg(input logic arm, input logic rep);
    return {3'h1, arm, rep, clr, 2'b00};
  endfunction

  // bounded wait on busy (2), open strobe (1) or supply strobe (0)
  task automatic wait_for(input int sel, input logic val);
    logic [2:0] v;
    int         n;
    n = 0;
    v = {busy, t_open, t_sup};
    while (v[sel] !== val && n < 1000)
    begin
      @(negedge clk_in);
      v = {busy, t_open, t_sup};
      n++;
    end
    chk1("wait", val, v[sel]);
  endtask

  task automatic t_powerup();
    repeat (2) @(negedge clk_in);
    chk("busy sup", 5'h06, {2'h0, busy, t_sup, t_brg});
    wr(8'h14);
    chk("amp in_a", 5'h00, {3'h0, amp_en, in_a});
    wait_for(1, 1'b1);
    wait_for(2, 1'b0);
    repeat (3) @(negedge clk_in);
    chk("amp in_a", 5'h03, {3'h0, amp_en, in_a});
  endtask

  task automatic t_modes();
    logic [1:0] k;
    logic [1:0] acks;
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      wr({3'h0, 1'b1, k, 2'b11});
      chk("mode", {2'h0, k == 2'h0, k}, {2'h0, mute, in_b, in_a});
    end
    wr(8'h0C);
    chk1("amp", 1'b0, amp_en);
    wr(8'h1C);
    wr(8'h7F);
    wr(8'h80);
    chk("gain_a", 5'h1F, gain_a);
    chk("gain_b", 5'h00, gain_b);
    wr(8'h95);
    wr(8'hBF);
    chk("gain_b", 5'h15, gain_b);
    wr(dg(1'b0, 1'b0) | 8'h03);
    chk1("ilim", 1'b1, ilim);
    wr(dg(1'b0, 1'b0));
    chk1("ilim", 1'b0, ilim);
    bm.write_reg(8'hF8, 8'h00, acks);
    chk("nack", 5'h00, {3'h0, acks});
    bm.write_reg(8'hFB, 8'h00, acks);
    chk("nack", 5'h00, {3'h0, acks});
    chk1("amp", 1'b1, amp_en);
  endtask

  task automatic t_oneshot();
    wr(8'h5F);
    wr(dg(1'b1, 1'b0));
    chk1("busy", 1'b1, busy);
    wait_for(1, 1'b1);
    wait_for(2, 1'b0);
    wr(dg(1'b1, 1'b0));
    chk1("busy", 1'b0, busy);
    wr(dg(1'b0, 1'b0));
    wr(dg(1'b1, 1'b0));
    chk1("busy", 1'b1, busy);
    wait_for(2, 1'b0);
    wr(8'h40);
  endtask

  task automatic t_fault();
    wr(dg(1'b0, 1'b0));
    wr(dg(1'b1, 1'b0));
    fault_cond = 5'h04;
    repeat (5) @(negedge clk_in);
    chk("flt amp", 5'h00, {3'h0, fault_oe_n, amp_en});
    fault_cond = 5'h00;
    repeat (12) @(negedge clk_in);
    chk1("flt", 1'b0, fault_oe_n);
    clr = ~clr;
    wr(dg(1'b0, 1'b0));
    chk("flt amp", 5'h03, {3'h0, fault_oe_n, amp_en});
    for (int b = 3; b < 5; b++)
      for (int m = 0; m < 2; m++)
      begin
        wr({3'h2, (m == 1) ? (5'h01 << b) : 5'h00});
        fault_cond = (5'h01 << b) | 5'h04;
        repeat (5) @(negedge clk_in);
        chk("flt amp", {3'h0, m == 1, 1'b0}, {3'h0, fault_oe_n, amp_en});
        fault_cond = 5'h00;
        clr = ~clr;
        wr(dg(1'b0, 1'b0));
        chk("flt amp", 5'h03, {3'h0, fault_oe_n, amp_en});
      end
  endtask

  task automatic t_repeat();
    wr(dg(1'b0, 1'b1));
    wr(dg(1'b1, 1'b1));
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    wait_for(0, 1'b1);
    wr(dg(1'b1, 1'b0));
    wait_for(2, 1'b0);
    repeat (500) @(negedge clk_in);
    chk1("busy", 1'b0, busy);
  endtask

  task automatic t_abort();
    rst_in = 1'b1;
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    clr = 1'b1;
    wr(dg(1'b0, 1'b0));
    chk1("busy", 1'b0, busy);
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    rst_in = 1'b1;
    fault_cond = 5'h00;
    clr = 1'b0;
    adr_sel = 1'b1;
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    t_powerup();
    t_modes();
    t_oneshot();
    t_fault();
    t_repeat();
    t_abort();
    tally_and_finish();
  end
endmodule
